// *** hdl/arlc_result_alu.sv ***
`timescale 1ns/1ps
`default_nettype none
module arlc_result_alu
	import arlc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	input  wire logic        converter_enable_bit,
	input  wire logic        repeat_mode,
	input  wire logic [1:0]  sample_count_sel,
	input  wire logic        cycle_start,
	input  wire logic        sample_valid,
	input  wire logic [9:0]  sample_data,
	input  wire logic        cycle_end,
	input  wire logic        conversion_error,
	input  wire logic        trigger_pin4,
	input  wire logic        trigger_pin2,
	output logic             restart_cycle,
	output logic             converter_irq_summary,
	output logic             limit_irq
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] pin_meta_r;
	logic [1:0] pin_sync_r;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pin_meta_r <= 2'h0;
			pin_sync_r <= 2'h0;
		end else begin
			pin_meta_r <= {trigger_pin4, trigger_pin2};
			pin_sync_r <= pin_meta_r;
		end
	end

	// ------------------------------------------------------------
	// thresholds
	// ------------------------------------------------------------
	logic [11:0] upper_threshold;
	logic [11:0] lower_threshold;

	arlc_regfile u_regfile (
		.ref_clk         (ref_clk),
		.rst_n           (rst_n),
		.wr_en           (reg_wr),
		.addr            (reg_addr),
		.wdata           (reg_wdata),
		.upper_threshold (upper_threshold),
		.lower_threshold (lower_threshold)
	);

	// ------------------------------------------------------------
	// compare mode and value
	// ------------------------------------------------------------
	arlc_cmp_e   cmp_mode;
	logic [11:0] average;
	logic [11:0] cmp_value;
	logic        cmp_fire;
	logic        over_upper;
	logic        under_lower;
	logic [15:0] sum_r;
	logic [15:0] sum_nxt;
	logic [9:0]  max_r;
	logic [9:0]  max_nxt;
	logic [9:0]  min_r;
	logic [9:0]  min_nxt;

	function automatic logic [11:0] arlc_shift_avg(input logic [15:0] s,
		input logic [1:0] sel);
		logic [15:0] sh;
		sh = s;
		unique case (sel)
		ARLC_CNT_16: sh = s >> 2;
		ARLC_CNT_32: sh = s >> 3;
		ARLC_CNT_64: sh = s >> 4;
		ARLC_CNT_SINGLE: sh = s;
		endcase
		return sh[11:0];
	endfunction

	always_comb begin
		if (!repeat_mode)
			cmp_mode = ARLC_CMP_NONE;
		else if (sample_count_sel == ARLC_CNT_SINGLE)
			cmp_mode = ARLC_CMP_SAMPLE;
		else
			cmp_mode = ARLC_CMP_AVERAGE;
	end

	assign average = arlc_shift_avg(sum_r, sample_count_sel);

	always_comb begin
		unique case (cmp_mode)
		ARLC_CMP_SAMPLE: begin
			cmp_value = {2'b00, sample_data};
			cmp_fire  = sample_valid && !cycle_start;
		end
		ARLC_CMP_AVERAGE: begin
			cmp_value = average;
			cmp_fire  = cycle_end;
		end
		default: begin
			cmp_value = 12'h000;
			cmp_fire  = 1'b0;
		end
		endcase
	end

	arlc_limit_cmp u_cmp (
		.value           (cmp_value),
		.upper_threshold (upper_threshold),
		.lower_threshold (lower_threshold),
		.over_upper      (over_upper),
		.under_lower     (under_lower)
	);

	// ------------------------------------------------------------
	// accumulator and min/max trackers
	// ------------------------------------------------------------
	always_comb begin
		sum_nxt = sum_r;
		max_nxt = max_r;
		min_nxt = min_r;
		if (cycle_start) begin
			sum_nxt = 16'h0000;
			max_nxt = ARLC_MAX_INIT;
			min_nxt = ARLC_MIN_INIT;
		end else if (sample_valid) begin
			sum_nxt = sum_r + {6'h00, sample_data};
			if (sample_data > max_r)
				max_nxt = sample_data;
			if (sample_data < min_r)
				min_nxt = sample_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sum_r <= 16'h0000;
			max_r <= ARLC_MAX_INIT;
			min_r <= ARLC_MIN_INIT;
		end else begin
			sum_r <= sum_nxt;
			max_r <= max_nxt;
			min_r <= min_nxt;
		end
	end

	// ------------------------------------------------------------
	// status flags and irq summary
	// ------------------------------------------------------------
	logic       done_r;
	logic       done_nxt;
	logic       err_r;
	logic       err_nxt;
	logic       upper_flt_r;
	logic       upper_flt_nxt;
	logic       lower_flt_r;
	logic       lower_flt_nxt;
	logic [1:0] pin_cap_r;
	logic [1:0] pin_cap_nxt;
	logic       irq_r;
	logic       irq_nxt;
	logic       status_read;
	logic       hit_upper;
	logic       hit_lower;

	assign status_read = reg_rd && (reg_addr == ARLC_CONVERTER_CYCLE_STATUS);
	assign hit_upper   = cmp_fire && over_upper;
	assign hit_lower   = cmp_fire && under_lower;

	always_comb begin
		done_nxt      = done_r;
		err_nxt       = err_r;
		upper_flt_nxt = upper_flt_r;
		lower_flt_nxt = lower_flt_r;
		pin_cap_nxt   = pin_cap_r;
		irq_nxt       = irq_r;
		if (cycle_start) begin
			done_nxt      = 1'b0;
			err_nxt       = 1'b0;
			upper_flt_nxt = 1'b0;
			lower_flt_nxt = 1'b0;
		end
		if (conversion_error)
			err_nxt = 1'b1;
		if (cycle_end) begin
			done_nxt    = 1'b1;
			pin_cap_nxt = pin_sync_r;
		end
		if (status_read)
			irq_nxt = 1'b0;
		if (hit_upper) begin
			upper_flt_nxt = 1'b1;
			irq_nxt       = 1'b1;
		end
		if (hit_lower) begin
			lower_flt_nxt = 1'b1;
			irq_nxt       = 1'b1;
		end
		if (cycle_end || conversion_error)
			irq_nxt = 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			done_r      <= ARLC_STATUS_RST[ARLC_ST_DONE];
			err_r       <= 1'b0;
			upper_flt_r <= 1'b0;
			lower_flt_r <= 1'b0;
			pin_cap_r   <= 2'h0;
			irq_r       <= 1'b0;
		end else begin
			done_r      <= done_nxt;
			err_r       <= err_nxt;
			upper_flt_r <= upper_flt_nxt;
			lower_flt_r <= lower_flt_nxt;
			pin_cap_r   <= pin_cap_nxt;
			irq_r       <= irq_nxt;
		end
	end

	assign converter_irq_summary = irq_r;
	assign limit_irq             = upper_flt_r || lower_flt_r;

	// repeat until fault or converter disabled
	assign restart_cycle = cycle_end && repeat_mode && converter_enable_bit
		&& !hit_upper && !hit_lower && !upper_flt_r && !lower_flt_r;

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	logic [7:0] status_byte;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	always_comb begin
		status_byte = 8'h00;
		status_byte[ARLC_ST_DONE]  = done_r;
		status_byte[ARLC_ST_ERR]   = err_r;
		status_byte[ARLC_ST_UPPER] = upper_flt_r;
		status_byte[ARLC_ST_LOWER] = lower_flt_r;
		status_byte[ARLC_ST_PIN4]  = pin_cap_r[1];
		status_byte[ARLC_ST_PIN2]  = pin_cap_r[0];
	end

	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_rd) begin
			unique case (reg_addr)
			ARLC_UPPER_THRESHOLD_HIGH: rdata_nxt = {4'h0, upper_threshold[11:8]};
			ARLC_UPPER_THRESHOLD_LOW:  rdata_nxt = upper_threshold[7:0];
			ARLC_LOWER_THRESHOLD_HIGH: rdata_nxt = {4'h0, lower_threshold[11:8]};
			ARLC_LOWER_THRESHOLD_LOW:  rdata_nxt = lower_threshold[7:0];
			ARLC_SAMPLE_TOTAL_HIGH:    rdata_nxt = sum_r[15:8];
			ARLC_SAMPLE_TOTAL_LOW:     rdata_nxt = sum_r[7:0];
			ARLC_LARGEST_SAMPLE_HIGH:  rdata_nxt = {6'h00, max_r[9:8]};
			ARLC_LARGEST_SAMPLE_LOW:   rdata_nxt = max_r[7:0];
			ARLC_SMALLEST_SAMPLE_HIGH: rdata_nxt = {6'h00, min_r[9:8]};
			ARLC_SMALLEST_SAMPLE_LOW:  rdata_nxt = min_r[7:0];
			ARLC_CONVERTER_CYCLE_STATUS: rdata_nxt = status_byte;
			default:                   rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			rdata_r <= 8'h00;
		else
			rdata_r <= rdata_nxt;
	end

	assign reg_rdata = rdata_r;

endmodule // arlc_result_alu
`default_nettype wire

// *** hdl/arlc_pkg.sv ***
`default_nettype none
package arlc_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ARLC_UPPER_THRESHOLD_HIGH = 8'h63;
	localparam logic [7:0] ARLC_UPPER_THRESHOLD_LOW  = 8'h64;
	localparam logic [7:0] ARLC_LOWER_THRESHOLD_HIGH = 8'h65;
	localparam logic [7:0] ARLC_LOWER_THRESHOLD_LOW  = 8'h66;
	localparam logic [7:0] ARLC_SAMPLE_TOTAL_HIGH    = 8'h94;
	localparam logic [7:0] ARLC_SAMPLE_TOTAL_LOW     = 8'h95;
	localparam logic [7:0] ARLC_LARGEST_SAMPLE_HIGH  = 8'h96;
	localparam logic [7:0] ARLC_LARGEST_SAMPLE_LOW   = 8'h97;
	localparam logic [7:0] ARLC_SMALLEST_SAMPLE_HIGH = 8'h98;
	localparam logic [7:0] ARLC_SMALLEST_SAMPLE_LOW  = 8'h99;
	localparam logic [7:0] ARLC_CONVERTER_CYCLE_STATUS = 8'h9a;

	// ------------------------------------------------------------
	// status field positions
	// ------------------------------------------------------------
	localparam int ARLC_ST_DONE  = 7;
	localparam int ARLC_ST_ERR   = 6;
	localparam int ARLC_ST_UPPER = 5;
	localparam int ARLC_ST_LOWER = 4;
	localparam int ARLC_ST_PIN4  = 1;
	localparam int ARLC_ST_PIN2  = 0;

	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int ARLC_SAMPLE_W = 10;
	localparam int ARLC_SUM_W    = 16;
	localparam int ARLC_THR_W    = 12;
	localparam logic [11:0] ARLC_UPPER_RST   = 12'hfff;
	localparam logic [11:0] ARLC_LOWER_RST   = 12'h000;
	localparam logic [9:0]  ARLC_MIN_INIT    = 10'h3ff;
	localparam logic [9:0]  ARLC_MAX_INIT    = 10'h000;
	localparam logic [7:0]  ARLC_STATUS_RST  = 8'h80;

	// ------------------------------------------------------------
	// sample-count selection codes
	// ------------------------------------------------------------
	localparam logic [1:0] ARLC_CNT_SINGLE = 2'b00;
	localparam logic [1:0] ARLC_CNT_16     = 2'b01;
	localparam logic [1:0] ARLC_CNT_32     = 2'b10;
	localparam logic [1:0] ARLC_CNT_64     = 2'b11;

	typedef enum logic [1:0] {
		ARLC_CMP_NONE,
		ARLC_CMP_SAMPLE,
		ARLC_CMP_AVERAGE
	} arlc_cmp_e;

endpackage
`default_nettype wire

// *** hdl/arlc_regfile.sv ***
`timescale 1ns/1ps
`default_nettype none
module arlc_regfile
	import arlc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        wr_en,
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wdata,
	output logic      [11:0] upper_threshold,
	output logic      [11:0] lower_threshold
);

	// ------------------------------------------------------------
	// threshold registers
	// ------------------------------------------------------------
	logic [11:0] upper_r;
	logic [11:0] upper_nxt;
	logic [11:0] lower_r;
	logic [11:0] lower_nxt;

	always_comb begin
		upper_nxt = upper_r;
		lower_nxt = lower_r;
		if (wr_en) begin
			unique case (addr)
			ARLC_UPPER_THRESHOLD_HIGH: upper_nxt[11:8] = wdata[3:0];
			ARLC_UPPER_THRESHOLD_LOW:  upper_nxt[7:0]  = wdata;
			ARLC_LOWER_THRESHOLD_HIGH: lower_nxt[11:8] = wdata[3:0];
			ARLC_LOWER_THRESHOLD_LOW:  lower_nxt[7:0]  = wdata;
			default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			upper_r <= ARLC_UPPER_RST;
			lower_r <= ARLC_LOWER_RST;
		end else begin
			upper_r <= upper_nxt;
			lower_r <= lower_nxt;
		end
	end

	assign upper_threshold = upper_r;
	assign lower_threshold = lower_r;

endmodule // arlc_regfile
`default_nettype wire

// *** hdl/arlc_limit_cmp.sv ***
`timescale 1ns/1ps
`default_nettype none
module arlc_limit_cmp
	import arlc_pkg::*;
(
	input  wire logic [11:0] value,
	input  wire logic [11:0] upper_threshold,
	input  wire logic [11:0] lower_threshold,
	output logic             over_upper,
	output logic             under_lower
);

	// ------------------------------------------------------------
	// strict compare: 0x000 / 0xfff never fault
	// ------------------------------------------------------------
	assign over_upper  = value > upper_threshold;
	assign under_lower = value < lower_threshold;

endmodule // arlc_limit_cmp
`default_nettype wire

// *** test/arlc_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module arlc_props (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       converter_enable_bit,
	input wire logic       repeat_mode,
	input wire logic [1:0] sample_count_sel,
	input wire logic       cycle_start,
	input wire logic       sample_valid,
	input wire logic       cycle_end,
	input wire logic       conversion_error,
	input wire logic       restart_cycle,
	input wire logic       converter_irq_summary,
	input wire logic       limit_irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire logic st_rd = reg_rd && reg_addr == 8'h9a;

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	irq_clear_a: assert property (st_rd && !sample_valid
		&& !cycle_end && !conversion_error |=> !converter_irq_summary)
		else $error("status read left irq set");
	done_irq_a: assert property (cycle_end
		|=> converter_irq_summary) else $error("done without irq");
	flt_hold_a: assert property ($fell(limit_irq)
		|-> $past(cycle_start)) else $error("fault dropped early");
	flt_bits_a: assert property (st_rd
		|=> (reg_rdata[5:4] != 2'h0) == $past(limit_irq))
		else $error("fault bits differ");
	st_rsvd_a: assert property (st_rd
		|=> reg_rdata[3:2] == 2'h0) else $error("status bits 3..2 set");
	mm_rsvd_a: assert property (reg_rd && (reg_addr == 8'h96
		|| reg_addr == 8'h98) |=> reg_rdata[7:2] == 6'h00)
		else $error("min max high reserved set");
	restart_gate_a: assert property (restart_cycle
		|-> cycle_end && converter_enable_bit && repeat_mode && !limit_irq)
		else $error("restart not allowed");
	restart_go_a: assert property (cycle_end && repeat_mode
		&& converter_enable_bit && sample_count_sel == 2'h0
		&& !limit_irq |-> restart_cycle) else $error("restart missing");
	fault_src_a: assert property ($rose(limit_irq)
		|-> $past(repeat_mode) && ($past(sample_count_sel) == 2'h0
		? $past(sample_valid) : $past(cycle_end)))
		else $error("fault without cause");
	cover property (cycle_end && restart_cycle);
	cover property ($rose(limit_irq));
	cover property (st_rd && converter_irq_summary);
endmodule // arlc_props
bind arlc_result_alu arlc_props i_props (.*);
`default_nettype wire

// *** test/arlc_sar_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module arlc_sar_model (
	input  wire logic       ref_clk,
	input  wire logic       restart_cycle,
	output logic            cycle_start,
	output logic            sample_valid,
	output logic      [9:0] sample_data,
	output logic            cycle_end,
	output logic            conversion_error
);
	logic restarted;
	initial {cycle_start, sample_valid, sample_data, cycle_end,
		conversion_error, restarted} = '0;

	// one cycle of n codes, first + i * step, gap + 1 idle cycles apart
	task automatic run(input int n, input logic [9:0] first,
		input logic [9:0] step, input int gap, input logic err);
		logic [9:0] v;
		v = first;
		@(posedge ref_clk);
		cycle_start <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			cycle_start  <= 1'b0;
			sample_valid <= 1'b1;
			sample_data  <= v;
			@(posedge ref_clk);
			sample_valid <= 1'b0;
			sample_data  <= ~v;
			v = v + step;
			repeat (gap) @(posedge ref_clk);
		end
		cycle_end        <= 1'b1;
		conversion_error <= err;
		#1 restarted = restart_cycle;
		@(posedge ref_clk);
		cycle_end        <= 1'b0;
		conversion_error <= 1'b0;
		@(posedge ref_clk);
	endtask
endmodule // arlc_sar_model
`default_nettype wire

// *** test/test_adc_result_alu_limit_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_adc_result_alu_limit_checker;
	logic       ref_clk, rst_n, reg_wr, reg_rd, converter_enable_bit;
	logic       repeat_mode, trigger_pin4, trigger_pin2, restart_cycle;
	logic       converter_irq_summary, limit_irq, cycle_start;
	logic       sample_valid, cycle_end, conversion_error;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [1:0] sample_count_sel;
	logic [9:0] sample_data;
	int         err_count = 0;
	int         n_checks = 0;

	arlc_result_alu i_dut (.*);
	arlc_sar_model i_sar (.*);
	always #20 ref_clk = ~ref_clk;

	// ------------------------------------------------------------
	// bus and compare helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic rd16(input logic [7:0] a, input logic [15:0] v);
		rd(a, v[15:8]);
		rd(a + 8'h01, v[7:0]);
	endtask
	task automatic thr(input logic [11:0] up, input logic [11:0] lo);
		wr(8'h63, {4'h0, up[11:8]});
		wr(8'h64, up[7:0]);
		wr(8'h65, {4'h0, lo[11:8]});
		wr(8'h66, lo[7:0]);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		logic [7:0] a[11] = '{8'h63, 8'h64, 8'h65, 8'h66, 8'h94, 8'h95,
			8'h96, 8'h97, 8'h98, 8'h99, 8'h9a};
		logic [7:0] e[11] = '{8'h0f, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h03, 8'hff, 8'h80};
		foreach (a[i]) rd(a[i], e[i]);
		rd(8'h70, 8'h00);
		wr(8'h94, 8'h5a);
		rd(8'h94, 8'h00);
		wr(8'h65, 8'hf3);
		rd(8'h65, 8'h03);
		$display("register map done");
	endtask
	task automatic t_avg;
		int n, f, sum, sample_total;
		for (int s = 1; s < 4; s++) begin
			for (int k = 0; k < 2; k++) begin
				n = 8 << s;
				f = 100 - 60 * k;
				sum = n * f + 3 * n * (n - 1) / 2;
				sample_total = sum >> (s + 1);
				thr(12'(sample_total - k), 12'h000);
				repeat_mode          <= 1'b1;
				converter_enable_bit <= 1'b1;
				sample_count_sel     <= 2'(s);
				i_sar.run(n, 10'(f), 10'h003, k, 1'b0);
				rd16(8'h94, 16'(sum));
				rd16(8'h96, 16'(f + 3 * (n - 1)));
				rd16(8'h98, 16'(f));
				chk(limit_irq, 16'(k));
				rd(8'h9a, k ? 8'ha0 : 8'h80);
			end
		end
		$display("averaging done");
	endtask
	task automatic t_single;
		logic [9:0] v[3] = '{10'h12d, 10'h12c, 10'h0c7};
		logic [7:0] st[3] = '{8'ha0, 8'h80, 8'h90};
		logic       r[3] = '{1'b0, 1'b1, 1'b0};
		thr(12'h12c, 12'h0c8);
		sample_count_sel <= 2'h0;
		foreach (v[i]) begin
			i_sar.run(1, v[i], 10'h000, 0, 1'b0);
			chk(i_sar.restarted, r[i]);
			rd(8'h9a, st[i]);
		end
		thr(12'hfff, 12'h000);
		i_sar.run(2, 10'h000, 10'h3ff, 1, 1'b0);
		chk(i_sar.restarted, 1'b1);
		rd(8'h9a, 8'h80);
		rd16(8'h96, 16'h03ff);
		@(posedge ref_clk);
		converter_enable_bit <= 1'b0;
		i_sar.run(1, 10'h12d, 10'h000, 0, 1'b0);
		chk(i_sar.restarted, 1'b0);
		$display("single sample done");
	endtask
	task automatic t_status;
		rd(8'h9a, 8'h80);
		chk(converter_irq_summary, 1'b0);
		thr(12'h064, 12'h000);
		repeat_mode          <= 1'b0;
		converter_enable_bit <= 1'b1;
		trigger_pin4         <= 1'b1;
		i_sar.run(4, 10'h384, 10'h00a, 0, 1'b1);
		chk(converter_irq_summary, 1'b1);
		rd(8'h9a, 8'hc2);
		chk(converter_irq_summary, 1'b0);
		rd16(8'h94, 16'h0e4c);
		@(posedge ref_clk);
		trigger_pin4 <= 1'b0;
		trigger_pin2 <= 1'b1;
		i_sar.run(1, 10'h000, 10'h000, 0, 1'b0);
		rd(8'h9a, 8'h81);
		$display("status done");
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		{rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, converter_enable_bit,
			repeat_mode, sample_count_sel, trigger_pin4, trigger_pin2} = '0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset;
		t_avg;
		t_single;
		t_status;
		end_sim;
	end
	initial begin
		#200000;
		err_count++;
		end_sim;
	end
endmodule // test_adc_result_alu_limit_checker
`default_nettype wire
